// [logic/i2c_xfer_consts.svh]
/*
  Register offsets, field positions, reset values and bus timing for the I2C transfer controller.
  Assumes pclk runs at 10 MHz; every time below is in nanoseconds.
*/
`ifndef I2C_XFER_CONSTS_SVH
`define I2C_XFER_CONSTS_SVH

`define CLK_PERIOD_NS 100
`define NS2CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define T_HD_STA_STD_NS 4000
`define T_HD_STA_FST_NS 600
`define T_SU_STO_STD_NS 4000
`define T_SU_STO_FST_NS 600
`define T_SU_STA_STD_NS 4700
`define T_SU_STA_FST_NS 600
`define T_LOW_STD_NS 4700
`define T_LOW_FST_NS 1300
`define T_HIGH_STD_NS 4000
`define T_HIGH_FST_NS 600

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SHIFT 8'h08
`define REG_LOCAL_ADDR 8'h0C

`define CTRL_START_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_WREL_BIT 2
`define CTRL_ACK_BIT 3
`define CTRL_STRETCH_BIT 4
`define CTRL_FAST_BIT 5
`define CTRL_RESET 3'h0
`define LOCAL_ADDR_RESET 7'h00

`define ST_MASTER_BIT 0
`define ST_ACKD_BIT 1
`define ST_TRC_BIT 2
`define ST_EV_LSB 3
`define ST_HOLD_BIT 7
`define EV_ADDR_END 0
`define EV_ADDR_MATCH 1
`define EV_XFER_END 2
`define EV_STOP 3

`endif

// [logic/i2c_xfer_pkg.sv]
/*
  Types shared by the I2C transfer controller and its line synchroniser.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none
package i2c_xfer_pkg;
  typedef enum logic [3:0] {
    M_IDLE, M_START_HOLD, M_LOW, M_HIGH_WAIT, M_HIGH, M_RS_LOW, M_RS_WAIT,
    M_RS_SETUP, M_STOP_LOW, M_STOP_WAIT, M_STOP_SETUP
  } mstate_e;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } line_s;

  typedef struct packed {
    logic ack_enable;
    logic stretch_timing_select;
    logic fast_mode;
  } ctrl_s;
endpackage
`default_nettype wire

// [logic/i2c_line_sync.sv]
/*
  Two-flop synchroniser with edge detection for one bus line.
  Assumes the raw level is asynchronous to pclk; an idle bus line reads high.
*/
`default_nettype none
module i2c_line_sync
  import i2c_xfer_pkg::*;
(
  input  wire logic pclk,    // System clock.
  input  wire logic presetn, // Asynchronous reset, active low.
  input  wire logic raw,     // Line level from the pin.
  output var  line_s line    // Synchronised level and edge pulses.
);
  logic [2:0] stage;
  logic [2:0] next_stage;

  always_comb begin
    next_stage = {stage[1:0], raw};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= 3'h7;
    end else begin
      stage <= next_stage;
    end
  end

  // Edges compare the second and third flops so the first one feeds nothing else.
  assign line = '{level: stage[1], rise: stage[1] & ~stage[2], fall: ~stage[1] & stage[2]};
endmodule
`default_nettype wire

// [logic/i2c_xfer_ctrl.sv]
/*
  I2C byte transfer controller for master and slave roles, with an APB register slave.
  Assumes open-drain lines resolved outside from the enables, and pclk at 10 MHz.
*/
`default_nettype none
`include "i2c_xfer_consts.svh"
module i2c_xfer_ctrl
  import i2c_xfer_pkg::*;
(
  input  wire logic        pclk,                // System clock, 10 MHz.
  input  wire logic        presetn,             // Asynchronous reset, active low.
  input  wire logic        psel,                // APB select.
  input  wire logic        penable,             // APB access phase.
  input  wire logic        pwrite,              // APB write when high.
  input  wire logic [7:0]  paddr,               // APB byte address.
  input  wire logic [31:0] pwdata,              // APB write data.
  output logic      [31:0] prdata,              // APB read data.
  output logic             pready,              // APB ready.
  output logic             pslverr,             // APB error on unmapped address.
  input  wire logic        bus_clock_line_in,   // Clock line level.
  output logic             bus_clock_line_out,  // Clock line drive value, always low.
  output logic             bus_clock_line_oe,   // High while pulling the clock line low.
  input  wire logic        bus_data_line_in,    // Data line level.
  output logic             bus_data_line_out,   // Data line drive value, always low.
  output logic             bus_data_line_oe,    // High while pulling the data line low.
  output logic             bus_event_interrupt  // One-cycle pulse on any bus event.
);
  line_s       scl_l;
  line_s       sda_l;
  ctrl_s       ctrl, next_ctrl;
  mstate_e     mst, next_mst;
  logic [5:0]  tmr, next_tmr;
  logic [6:0]  local_addr, next_local_addr;
  logic [7:0]  tx, next_tx;
  logic [7:0]  rx, next_rx;
  logic [3:0]  rise_cnt, next_rise_cnt;
  logic [3:0]  ev, next_ev;
  logic [3:0]  ev_set;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic        master_comm_flag, next_master;
  logic        ack_detected_flag, next_ack_det;
  logic        transmit_direction_flag, next_trc;
  logic        slave_active, next_slave_active;
  logic        addr_phase, next_addr_phase;
  logic        hold, next_hold;
  logic        rw_bit, next_rw_bit;
  logic        mscl, next_mscl;
  logic        next_sda_oe, next_scl_oe;
  logic        wr, wr_ctrl, wr_status, wr_shift;
  logic        start_pulse, stop_pulse, wrel_pulse;
  logic        start_seen, stop_seen, engine_on, addr_match_now;

  i2c_line_sync u_scl_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (bus_clock_line_in),
    .line    (scl_l)
  );

  i2c_line_sync u_sda_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (bus_data_line_in),
    .line    (sda_l)
  );

  // Counts round up, and the timer runs one extra cycle at zero, so each time is a minimum.
  function automatic logic [5:0] cyc(input logic fast, input int std_ns, input int fst_ns);
    cyc = fast ? 6'(`NS2CYC(fst_ns)) : 6'(`NS2CYC(std_ns));
  endfunction

  assign wr          = psel & penable & pready & pwrite;
  assign wr_ctrl     = wr && (paddr == `REG_CTRL);
  assign wr_status   = wr && (paddr == `REG_STATUS);
  assign wr_shift    = wr && (paddr == `REG_SHIFT);
  assign start_pulse = wr_ctrl & pwdata[`CTRL_START_BIT];
  assign stop_pulse  = wr_ctrl & pwdata[`CTRL_STOP_BIT];
  assign wrel_pulse  = wr_ctrl & pwdata[`CTRL_WREL_BIT];
  assign start_seen  = sda_l.fall & scl_l.level;
  assign stop_seen   = sda_l.rise & scl_l.level;
  assign engine_on   = (master_comm_flag | slave_active) & ~hold & ~start_seen & ~stop_seen;
  assign addr_match_now = (rx[7:1] == local_addr);

  always_comb begin
    next_ctrl = ctrl;
    next_local_addr = local_addr;
    next_mst = mst;
    next_tmr = tmr;
    next_tx = tx;
    next_rx = rx;
    next_rise_cnt = rise_cnt;
    next_master = master_comm_flag;
    next_ack_det = ack_detected_flag;
    next_trc = transmit_direction_flag;
    next_slave_active = slave_active;
    next_addr_phase = addr_phase;
    next_hold = hold;
    next_rw_bit = rw_bit;
    next_mscl = mscl;
    next_sda_oe = bus_data_line_oe;
    next_prdata = prdata;
    next_pslverr = pslverr;
    ev_set = 4'h0;

    // Setting pready in the setup phase lets pready and read data come from flops with no wait state.
    next_pready = psel & ~penable & ~pready;
    if (psel && !penable) begin
      next_prdata = 32'h0;
      next_pslverr = 1'b0;
      unique case (paddr)
        `REG_CTRL: begin
          next_prdata[`CTRL_ACK_BIT] = ctrl.ack_enable;
          next_prdata[`CTRL_STRETCH_BIT] = ctrl.stretch_timing_select;
          next_prdata[`CTRL_FAST_BIT] = ctrl.fast_mode;
        end
        `REG_STATUS: begin
          next_prdata[`ST_MASTER_BIT] = master_comm_flag;
          next_prdata[`ST_ACKD_BIT] = ack_detected_flag;
          next_prdata[`ST_TRC_BIT] = transmit_direction_flag;
          next_prdata[`ST_EV_LSB +: 4] = ev;
          next_prdata[`ST_HOLD_BIT] = hold;
        end
        `REG_SHIFT:      next_prdata[7:0] = rx;
        `REG_LOCAL_ADDR: next_prdata[6:0] = local_addr;
        default:         next_pslverr = 1'b1;
      endcase
    end
    if (wr_ctrl) begin
      next_ctrl.ack_enable = pwdata[`CTRL_ACK_BIT];
      next_ctrl.stretch_timing_select = pwdata[`CTRL_STRETCH_BIT];
      next_ctrl.fast_mode = pwdata[`CTRL_FAST_BIT];
    end
    if (wr && (paddr == `REG_LOCAL_ADDR)) begin
      next_local_addr = pwdata[6:0];
    end

    if (stop_seen) begin
      next_master = 1'b0;
      next_slave_active = 1'b0;
      next_hold = 1'b0;
      next_trc = 1'b0;
      next_addr_phase = 1'b0;
      next_sda_oe = 1'b0;
      ev_set[`EV_STOP] = 1'b1;
    end else if (start_seen) begin
      next_rise_cnt = 4'h0;
      next_addr_phase = 1'b1;
      if (mst == M_START_HOLD) begin
        next_master = 1'b1;
        next_trc = 1'b1;
        next_hold = 1'b1;
      end else begin
        next_slave_active = 1'b1;
        next_trc = 1'b0;
      end
    end else if (hold) begin
      // A receiver held at the eighth clock follows ack_enable until released, so a late
      // clear still turns the coming acknowledge into a not-acknowledge.
      if (!transmit_direction_flag && rise_cnt == 4'h8) begin
        next_sda_oe = next_ctrl.ack_enable;
      end
      if (wr_shift) begin
        next_hold = 1'b0;
        if (transmit_direction_flag) begin
          next_tx = pwdata[7:0];
          next_sda_oe = ~pwdata[7];
          if (addr_phase) begin
            next_rw_bit = pwdata[0];
          end
        end
      end else if (wrel_pulse) begin
        next_hold = 1'b0;
        if (transmit_direction_flag && !master_comm_flag) begin
          next_trc = 1'b0;
          next_sda_oe = 1'b0;
        end
      end
    end else if (engine_on) begin
      if (scl_l.rise) begin
        next_rise_cnt = rise_cnt + 4'h1;
        if (rise_cnt < 4'h8) begin
          next_rx = {rx[6:0], sda_l.level};
        end else if (transmit_direction_flag) begin
          next_ack_det = ~sda_l.level;
        end
      end else if (scl_l.fall) begin
        if (rise_cnt >= 4'h1 && rise_cnt <= 4'h7) begin
          if (transmit_direction_flag) begin
            next_tx = {tx[6:0], 1'b1};
            next_sda_oe = ~tx[6];
          end
        end else if (rise_cnt == 4'h8) begin
          if (transmit_direction_flag) begin
            next_sda_oe = 1'b0;
          end else if (addr_phase) begin
            next_sda_oe = addr_match_now;
            next_rw_bit = rx[0];
            next_slave_active = addr_match_now;
          end else begin
            next_sda_oe = ctrl.ack_enable;
            if (!ctrl.stretch_timing_select) begin
              next_hold = 1'b1;
              ev_set[`EV_XFER_END] = 1'b1;
            end
          end
        end else if (rise_cnt == 4'h9) begin
          next_rise_cnt = 4'h0;
          if (!transmit_direction_flag) begin
            next_sda_oe = 1'b0;
          end
          if (addr_phase) begin
            next_addr_phase = 1'b0;
            next_hold = 1'b1;
            if (master_comm_flag) begin
              ev_set[`EV_ADDR_END] = 1'b1;
              next_trc = ~rw_bit;
            end else begin
              ev_set[`EV_ADDR_MATCH] = 1'b1;
              next_trc = rw_bit;
            end
          end else if (transmit_direction_flag || ctrl.stretch_timing_select) begin
            next_hold = 1'b1;
            ev_set[`EV_XFER_END] = 1'b1;
          end
        end
      end
    end

    // Master clock generator; a line that another party holds low simply waits here.
    unique case (mst)
      M_IDLE: begin
        if (start_pulse && scl_l.level && sda_l.level && !slave_active) begin
          next_sda_oe = 1'b1;
          next_tmr = cyc(ctrl.fast_mode, `T_HD_STA_STD_NS, `T_HD_STA_FST_NS);
          next_mst = M_START_HOLD;
        end
      end
      M_START_HOLD: begin
        if (tmr != 6'h00) begin
          next_tmr = tmr - 6'h01;
        end else begin
          next_mscl = 1'b1;
          next_tmr = cyc(ctrl.fast_mode, `T_LOW_STD_NS, `T_LOW_FST_NS);
          next_mst = M_LOW;
        end
      end
      M_LOW: begin
        if (hold && start_pulse) begin
          next_sda_oe = 1'b0;
          next_hold = 1'b0;
          next_tmr = cyc(ctrl.fast_mode, `T_LOW_STD_NS, `T_LOW_FST_NS);
          next_mst = M_RS_LOW;
        end else if (hold && stop_pulse) begin
          next_sda_oe = 1'b1;
          next_hold = 1'b0;
          next_tmr = cyc(ctrl.fast_mode, `T_LOW_STD_NS, `T_LOW_FST_NS);
          next_mst = M_STOP_LOW;
        end else if (!hold) begin
          if (tmr != 6'h00) begin
            next_tmr = tmr - 6'h01;
          end else begin
            next_mscl = 1'b0;
            next_mst = M_HIGH_WAIT;
          end
        end
      end
      M_HIGH_WAIT: begin
        if (scl_l.level) begin
          next_tmr = cyc(ctrl.fast_mode, `T_HIGH_STD_NS, `T_HIGH_FST_NS);
          next_mst = M_HIGH;
        end
      end
      M_HIGH: begin
        if (tmr != 6'h00) begin
          next_tmr = tmr - 6'h01;
        end else begin
          next_mscl = 1'b1;
          next_tmr = cyc(ctrl.fast_mode, `T_LOW_STD_NS, `T_LOW_FST_NS);
          next_mst = M_LOW;
        end
      end
      // Data is released (restart) or pulled low (stop) a full low time before the clock so no false stop or start appears.
      M_RS_LOW, M_STOP_LOW: begin
        if (tmr != 6'h00) begin
          next_tmr = tmr - 6'h01;
        end else begin
          next_mscl = 1'b0;
          next_mst = (mst == M_RS_LOW) ? M_RS_WAIT : M_STOP_WAIT;
        end
      end
      M_RS_WAIT: begin
        if (scl_l.level) begin
          next_tmr = cyc(ctrl.fast_mode, `T_SU_STA_STD_NS, `T_SU_STA_FST_NS);
          next_mst = M_RS_SETUP;
        end
      end
      M_RS_SETUP: begin
        if (tmr != 6'h00) begin
          next_tmr = tmr - 6'h01;
        end else begin
          next_sda_oe = 1'b1;
          next_tmr = cyc(ctrl.fast_mode, `T_HD_STA_STD_NS, `T_HD_STA_FST_NS);
          next_mst = M_START_HOLD;
        end
      end
      M_STOP_WAIT: begin
        if (scl_l.level) begin
          next_tmr = cyc(ctrl.fast_mode, `T_SU_STO_STD_NS, `T_SU_STO_FST_NS);
          next_mst = M_STOP_SETUP;
        end
      end
      M_STOP_SETUP: begin
        if (tmr != 6'h00) begin
          next_tmr = tmr - 6'h01;
        end else begin
          next_sda_oe = 1'b0;
          next_mst = M_IDLE;
        end
      end
    endcase

    // A hardware set wins over a software clear in the same cycle.
    next_ev = (ev & ~(wr_status ? pwdata[`ST_EV_LSB +: 4] : 4'h0)) | ev_set;
    next_scl_oe = next_mscl | (next_slave_active & next_hold);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      local_addr <= `LOCAL_ADDR_RESET;
      mst <= M_IDLE;
      tmr <= 6'h00;
      tx <= 8'hFF;
      rx <= 8'h00;
      rise_cnt <= 4'h0;
      ev <= 4'h0;
      master_comm_flag <= 1'b0;
      ack_detected_flag <= 1'b0;
      transmit_direction_flag <= 1'b0;
      slave_active <= 1'b0;
      addr_phase <= 1'b0;
      hold <= 1'b0;
      rw_bit <= 1'b0;
      mscl <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      bus_clock_line_out <= 1'b0;
      bus_clock_line_oe <= 1'b0;
      bus_data_line_out <= 1'b0;
      bus_data_line_oe <= 1'b0;
      bus_event_interrupt <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      local_addr <= next_local_addr;
      mst <= next_mst;
      tmr <= next_tmr;
      tx <= next_tx;
      rx <= next_rx;
      rise_cnt <= next_rise_cnt;
      ev <= next_ev;
      master_comm_flag <= next_master;
      ack_detected_flag <= next_ack_det;
      transmit_direction_flag <= next_trc;
      slave_active <= next_slave_active;
      addr_phase <= next_addr_phase;
      hold <= next_hold;
      rw_bit <= next_rw_bit;
      mscl <= next_mscl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      bus_clock_line_out <= 1'b0;
      bus_clock_line_oe <= next_scl_oe;
      bus_data_line_out <= 1'b0;
      bus_data_line_oe <= next_sda_oe;
      bus_event_interrupt <= |ev_set;
    end
  end

  logic fall8, fall9, rise9;
  assign fall8 = engine_on & scl_l.fall & (rise_cnt == 4'h8);
  assign fall9 = engine_on & scl_l.fall & (rise_cnt == 4'h9);
  assign rise9 = engine_on & scl_l.rise & (rise_cnt == 4'h8);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_start_flag;
    start_seen && mst == M_START_HOLD |=> master_comm_flag && hold;
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("start left master flag clear");
  property p_rs_wait;
    mst == M_RS_WAIT && !scl_l.level |=> mst == M_RS_WAIT && !bus_data_line_oe;
  endproperty
  a_rs_wait: assert property (p_rs_wait) else $error("restart did not wait for clock");
  property p_load;
    hold && wr_shift && transmit_direction_flag && engine_on == 1'b0 && !start_seen && !stop_seen
      |=> !hold && (bus_data_line_oe == !tx[7]);
  endproperty
  a_load: assert property (p_load) else $error("byte write did not drive first bit");
  property p_slave_ack;
    fall8 && addr_phase && !transmit_direction_flag
      |=> bus_data_line_oe == $past(addr_match_now) && slave_active == $past(addr_match_now);
  endproperty
  a_slave_ack: assert property (p_slave_ack) else $error("address ack wrong");
  property p_addr_end;
    fall9 && addr_phase && master_comm_flag |=> ev[`EV_ADDR_END] && hold;
  endproperty
  a_addr_end: assert property (p_addr_end) else $error("no address end event");
  property p_match;
    fall9 && addr_phase && slave_active |=> ev[`EV_ADDR_MATCH] && bus_clock_line_oe;
  endproperty
  a_match: assert property (p_match) else $error("matched slave did not stretch");
  property p_stretch8;
    fall8 && !addr_phase && !transmit_direction_flag && !ctrl.stretch_timing_select
      |=> hold && ev[`EV_XFER_END] && bus_data_line_oe == $past(ctrl.ack_enable);
  endproperty
  a_stretch8: assert property (p_stretch8) else $error("eighth clock stretch wrong");
  property p_stretch9;
    fall9 && !addr_phase && ctrl.stretch_timing_select |=> hold && ev[`EV_XFER_END];
  endproperty
  a_stretch9: assert property (p_stretch9) else $error("ninth clock stretch missing");
  property p_ack;
    rise9 && transmit_direction_flag |=> ack_detected_flag == !$past(sda_l.level);
  endproperty
  a_ack: assert property (p_ack) else $error("ack sample wrong");
  property p_wrel;
    hold && wrel_pulse && !wr_shift && transmit_direction_flag && slave_active
      && !start_seen && !stop_seen |=> !transmit_direction_flag && !bus_data_line_oe;
  endproperty
  a_wrel: assert property (p_wrel) else $error("wait release kept direction");
  property p_stop_wait;
    mst == M_STOP_WAIT && !scl_l.level |=> mst == M_STOP_WAIT && bus_data_line_oe;
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("stop did not wait");
  property p_stop_ev;
    stop_seen |=> ev[`EV_STOP] && !slave_active && !master_comm_flag;
  endproperty
  a_stop_ev: assert property (p_stop_ev) else $error("stop event missing");
  property p_hd_sta;
    mst == M_IDLE ##1 mst == M_START_HOLD
      |-> tmr == cyc(ctrl.fast_mode, `T_HD_STA_STD_NS, `T_HD_STA_FST_NS);
  endproperty
  a_hd_sta: assert property (p_hd_sta) else $error("start hold count wrong");
  property p_su_sto;
    mst == M_STOP_WAIT ##1 mst == M_STOP_SETUP
      |-> tmr == cyc(ctrl.fast_mode, `T_SU_STO_STD_NS, `T_SU_STO_FST_NS);
  endproperty
  a_su_sto: assert property (p_su_sto) else $error("stop setup count wrong");

  c_addr_end: cover property (fall9 && addr_phase && master_comm_flag);
  c_match: cover property (fall9 && addr_phase && slave_active);
  c_restart: cover property (mst == M_RS_SETUP ##1 mst == M_START_HOLD);
  c_stop: cover property (stop_seen);
endmodule
`default_nettype wire

// [test/i2c_slave_model.sv]
/* Behavioural I2C slave that acks its own address and the bytes written to it after it.
   Assumes pulled-up lines resolved by the bench from every enable. */
`default_nettype none
module i2c_slave_model #(parameter logic [6:0] ADDR = 7'h2A) (
  input  wire logic scl,    // Resolved clock line.
  input  wire logic sda,    // Resolved data line.
  input  wire logic slow,   // Stretch after each ninth clock once the address matched.
  input  wire logic [7:0] rbyte, // Byte sent back when addressed for reading.
  output logic      scl_oe, // High while holding the clock low.
  output logic      sda_oe  // High while pulling data low.
);
  timeunit 1ns;
  timeprecision 1ns;
  int         n = 10;
  logic [7:0] sh;
  logic       first;
  logic       matched;
  logic       rd = 1'b0;
  logic       nak = 1'b0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  always @(negedge sda) if (scl) begin
    n = 0;
    first = 1'b1;
    rd = 1'b0;
    nak = 1'b0;
  end
  always @(posedge sda) if (scl) n = 10;
  always @(posedge scl) if (n < 9) begin
    if (n < 8) sh = {sh[6:0], sda};
    else if (rd) nak = sda;
    n = n + 1;
  end
  always @(negedge scl) begin
    if (n == 8) begin
      if (first) begin
        matched = (sh[7:1] == ADDR);
        rd = matched & sh[0];
      end
      sda_oe = matched & (first | ~rd);
    end else if (n == 9) begin
      // After a not-acknowledge the model stops sending and leaves data released.
      sda_oe = rd & ~nak & ~rbyte[7];
      n = 0;
      first = 1'b0;
      // A slow far side proves the master waits for the line, not for its own timer.
      if (slow && matched) begin
        scl_oe = 1'b1;
        #3000 scl_oe = 1'b0;
      end
    end else if (rd && !nak && n >= 1 && n <= 7) begin
      sda_oe = ~rbyte[7 - n];
    end
  end
endmodule
`default_nettype wire

// [test/i2c_master_slave_transfer_tb.sv]
/* Bench: an APB master runs the controller as I2C master against a slave model.
   Assumes pulled-up lines, resolved here from both parties' enables. */
`default_nettype none
`include "i2c_xfer_consts.svh"
module i2c_master_slave_transfer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] slv_addr = 7'h2A;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00, dat;
  logic [31:0] pwdata = 32'h0, prdata, rd, st, mode, seed = 32'h62C825A4;
  logic pready, pslverr, err, c_oe, d_oe, s_coe, s_doe, c_out, d_out, irq, match;
  logic [6:0] a;
  logic [8:0] wsh;
  int n_fail = 0, checked = 0, cyc = 0, n_irq = 0, n_exp = 0;
  wire scl = ~(c_oe | s_coe);
  wire sda = ~(d_oe | s_doe);
  always #50 pclk = ~pclk;
  always @(posedge scl) wsh <= {wsh[7:0], sda};
  always @(posedge pclk) if (irq === 1'b1) n_irq <= n_irq + 1;
  i2c_xfer_ctrl u_i2c_xfer_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_clock_line_in(scl), .bus_clock_line_out(c_out),
    .bus_clock_line_oe(c_oe), .bus_data_line_in(sda), .bus_data_line_out(d_out),
    .bus_data_line_oe(d_oe), .bus_event_interrupt(irq));
  i2c_slave_model #(.ADDR(slv_addr)) u_i2c_slave_model (.scl(scl), .sda(sda), .slow(slow),
    .scl_oe(s_coe), .sda_oe(s_doe), .rbyte(~dat));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] frame(input logic [7:0] b, input logic ack);
    return {23'h0, b, ~ack};
  endfunction
  task automatic report_and_stop();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Polls status until a bit is set, then clears every event bit.
  task automatic wait_ev(input int bitn);
    do apb(1'b1 ^ 1'b1, `REG_STATUS, 32'h0); while (rd[bitn] !== 1'b1);
    st = rd;
    apb(1'b1, `REG_STATUS, 32'h78);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, `REG_LOCAL_ADDR, seed);
    apb(1'b0, `REG_LOCAL_ADDR, 32'h0);
    chk("local address", {25'h0, seed[6:0]}, rd);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      match = (i != 1);
      a = match ? slv_addr : slv_addr ^ (seed[14:8] | 7'h01);
      dat = (i == 0) ? 8'hFF : seed[7:0];
      slow <= i[1];
      mode = {26'h0, i[0], 5'h10};
      apb(1'b1, `REG_CTRL, mode);
      apb(1'b1, `REG_CTRL, mode | 32'h1);
      wait_ev(`ST_HOLD_BIT);
      chk("master flag", 32'h1, {31'h0, st[`ST_MASTER_BIT]});
      apb(1'b1, `REG_SHIFT, {24'h0, a, 1'b0});
      wait_ev(`EV_ADDR_END + `ST_EV_LSB);
      chk("address frame", frame({a, 1'b0}, match), {23'h0, wsh});
      chk("ack flag", {31'h0, match}, {31'h0, st[`ST_ACKD_BIT]});
      if (match) begin
        apb(1'b1, `REG_SHIFT, {24'h0, dat});
        wait_ev(`EV_XFER_END + `ST_EV_LSB);
        chk("data frame", frame(dat, 1'b1), {23'h0, wsh});
        apb(1'b1, `REG_CTRL, mode | 32'h1);
        wait_ev(`ST_HOLD_BIT);
        chk("restart no stop", 32'h0, {31'h0, st[`EV_STOP + `ST_EV_LSB]});
        apb(1'b1, `REG_SHIFT, {24'h0, a, 1'b1});
        wait_ev(`EV_ADDR_END + `ST_EV_LSB);
        chk("read direction", 32'h0, {31'h0, st[`ST_TRC_BIT]});
        apb(1'b1, `REG_CTRL, mode ^ 32'h18);
        apb(1'b1, `REG_SHIFT, 32'hFF);
        wait_ev(`EV_XFER_END + `ST_EV_LSB);
        chk("ack held", 32'h0, {31'h0, sda});
        apb(1'b0, `REG_SHIFT, 32'h0);
        chk("read byte", {24'h0, ~dat}, rd);
        apb(1'b1, `REG_CTRL, mode);
        apb(1'b1, `REG_CTRL, mode | 32'h4);
        wait_ev(`EV_XFER_END + `ST_EV_LSB);
        chk("nack frame", frame(~dat, 1'b0), {23'h0, wsh});
        n_exp += 4;
      end
      apb(1'b1, `REG_CTRL, mode | 32'h2);
      wait_ev(`EV_STOP + `ST_EV_LSB);
      chk("idle lines", 32'h3, {30'h0, scl, sda});
      n_exp += 2;
      $display("test %0d done", i);
      repeat (5) @(posedge pclk);
    end
    chk("event pulses", 32'(n_exp), 32'(n_irq));
    chk("drive levels", 32'h0, {30'h0, c_out, d_out});
    report_and_stop();
  end
endmodule
`default_nettype wire
